/* include/pis_cfg.svh */
// Offsets, field positions, reset values and fixed addresses of the
// priority interrupt sequencer. Included by the package and the core.
`ifndef PIS_CFG_SVH
`define PIS_CFG_SVH

`define PIS_NSRC 8
`define PIS_NSUB 4
`define PIS_SUMMARY_SRC 7
`define PIS_HWCLR_MASK 8'h40

`define PIS_A_CTRL 8'h00
`define PIS_A_STAT 8'h04
`define PIS_A_FLAG 8'h08
`define PIS_A_ENA 8'h0C
`define PIS_A_PRIO 8'h10
`define PIS_A_IVT 8'h14
`define PIS_A_SHD0 8'h18
`define PIS_A_SHD1 8'h1C
`define PIS_A_SHD2 8'h20
`define PIS_A_SHD3 8'h24

`define PIS_B_GHI 0
`define PIS_B_GLO 1
`define PIS_B_PEN 2
`define PIS_B_VTEN 3
`define PIS_B_SSEL 4

`define PIS_CTRL_RST 5'h00
`define PIS_ENA_RST 8'h00
`define PIS_PRIO_RST 8'hFF
`define PIS_IVT_RST 21'h00_0008
`define PIS_HI_ADDR 21'h00_0008
`define PIS_LO_ADDR 21'h00_0018

`endif

/* include/pis_pkg.sv */
// Types of the priority interrupt sequencer.
// Assumes pis_cfg.svh on the include path.
`include "pis_cfg.svh"
`default_nettype none
package pis_pkg;

  // Execution state of the CPU as seen by the sequencer
  typedef enum logic [1:0] {
    PIS_MAIN = 2'b00,
    PIS_LOW = 2'b01,
    PIS_HIM = 2'b10,
    PIS_HIL = 2'b11
  } pis_exec_t;

  // Vectoring sequence
  typedef enum logic [2:0] {
    PIS_IDLE = 3'b000,
    PIS_WAIT = 3'b001,
    PIS_LAT1 = 3'b010,
    PIS_LAT2 = 3'b011,
    PIS_LAT3 = 3'b100
  } pis_seq_t;

  // One saved CPU context
  typedef struct packed {
    logic [15:0] pclat;
    logic [15:0] prod;
    logic [15:0] fsr2;
    logic [15:0] fsr1;
    logic [15:0] fsr0;
    logic [7:0] bank_select_register;
    logic [7:0] working_register;
    logic [7:0] status;
  } pis_ctx_t;

endpackage : pis_pkg
`default_nettype wire

/* verilog/pis_core.sv */
// Priority interrupt sequencer: flags, resolution, vectoring, context.
// Assumes APB master, peripherals and CPU all run on pclk.
`include "pis_cfg.svh"
`default_nettype none
module pis_core
  import pis_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Peripheral events
  input wire logic [`PIS_NSRC-1:0] src_event,
  input wire logic [`PIS_NSUB-1:0] sub_flags,
  // CPU core
  input wire logic instr_done,
  input wire logic return_from_interrupt,
  input wire logic return_from_interrupt_restore,
  input wire logic [18:0] fetch_word,
  input wire pis_ctx_t cpu_ctx,
  output logic cpu_halt,
  output logic pc_push,
  output logic pc_pop,
  output logic pc_load,
  output logic [20:0] pc_value,
  output logic working_register_load,
  output logic [7:0] working_register_value,
  output logic ctx_restore,
  output var pis_ctx_t ctx_out
);

  localparam int NS = `PIS_NSRC;
  // Sources whose flag is cleared by hardware on vectoring
  localparam logic [NS-1:0] HW_CLR = `PIS_HWCLR_MASK;

  // ==========================================================
  // State
  logic [4:0] ctrl;
  logic [NS-1:0] flag;
  logic [NS-1:0] enable;
  logic [NS-1:0] prio;
  logic [20:0] ivt;
  pis_ctx_t shd_main;
  pis_ctx_t shd_low;
  pis_exec_t exec;
  pis_exec_t next_exec;
  pis_seq_t seq;
  pis_seq_t next_seq;
  logic [2:0] vec_q;
  logic lvl_q;

  function automatic logic [2:0] pis_first(input logic [NS-1:0] m);
    logic [2:0] r;
    r = 3'h0;
    for (int i = NS - 1; i >= 0; i--) begin
      if (m[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction : pis_first

  function automatic pis_ctx_t pis_ctx_wr(input pis_ctx_t c,
    input logic [1:0] w, input logic [31:0] d);
    pis_ctx_t r;
    r = c;
    case (w)
      2'h0: begin
        r.status = d[7:0];
        r.working_register = d[15:8];
        r.bank_select_register = d[23:16];
      end
      2'h1: begin
        r.fsr0 = d[15:0];
        r.fsr1 = d[31:16];
      end
      2'h2: begin
        r.fsr2 = d[15:0];
        r.prod = d[31:16];
      end
      default: begin
        r.pclat = d[15:0];
      end
    endcase
    return r;
  endfunction : pis_ctx_wr

  // ==========================================================
  // APB decode
  wire wr = psel & penable & pwrite & pready;
  wire h_ctrl = (paddr == `PIS_A_CTRL);
  wire h_stat = (paddr == `PIS_A_STAT);
  wire h_flag = (paddr == `PIS_A_FLAG);
  wire h_ena = (paddr == `PIS_A_ENA);
  wire h_prio = (paddr == `PIS_A_PRIO);
  wire h_ivt = (paddr == `PIS_A_IVT);
  wire h_shd = (paddr >= `PIS_A_SHD0) && (paddr <= `PIS_A_SHD3);
  wire [1:0] shd_w = 2'(paddr[3:2] - 2'h2);
  wire ghi = ctrl[`PIS_B_GHI];
  wire glo = ctrl[`PIS_B_GLO];
  wire pen = ctrl[`PIS_B_PEN];
  wire vten = ctrl[`PIS_B_VTEN];
  wire ssel = ctrl[`PIS_B_SSEL];
  wire pis_ctx_t shd_view = ssel ? shd_low : shd_main;
  wire [31:0] shd_rd = (shd_w == 2'h0) ? {8'h00, shd_view.bank_select_register,
                         shd_view.working_register, shd_view.status} :
                       (shd_w == 2'h1) ? {shd_view.fsr1, shd_view.fsr0} :
                       (shd_w == 2'h2) ? {shd_view.prod, shd_view.fsr2} :
                       {16'h0000, shd_view.pclat};
  wire hit = h_ctrl | h_stat | h_flag | h_ena | h_prio | h_ivt | h_shd;
  wire [31:0] rd_word =
    h_ctrl ? {27'h000_0000, ctrl} :
    h_stat ? {21'h00_0000, vec_q, 3'h0, seq, exec} :
    h_flag ? {24'h00_0000, flag} :
    h_ena ? {24'h00_0000, enable} :
    h_prio ? {24'h00_0000, prio} :
    h_ivt ? {11'h000, ivt} :
    h_shd ? shd_rd : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      prdata <= (psel & ~penable & ~pwrite) ? rd_word : 32'h0000_0000;
      pslverr <= psel & ~penable & ~hit;
    end
  end

  // ==========================================================
  // Resolution
  wire [NS-1:0] pend = flag & enable;
  wire [NS-1:0] hi_m = pend & (pen ? prio : {NS{1'b1}}) & {NS{ghi}};
  wire [NS-1:0] lo_m = pen ? (pend & ~prio & {NS{glo}}) : {NS{1'b0}};
  wire accept_ok = (exec == PIS_MAIN) ? (|hi_m | |lo_m) :
                   (exec == PIS_LOW) ? |hi_m : 1'b0;
  wire sel_lvl = |hi_m;
  wire [2:0] sel_vec = sel_lvl ? pis_first(hi_m) : pis_first(lo_m);
  wire still = (lvl_q ? hi_m[vec_q] : lo_m[vec_q]) &
               ((exec == PIS_MAIN) | (exec == PIS_LOW & lvl_q));
  wire take = (seq == PIS_LAT1) & still;
  wire ret_ok = return_from_interrupt & (exec != PIS_MAIN) &
                ((seq == PIS_IDLE) | (seq == PIS_WAIT));
  // software clearing both enables returns to main
  wire force_main = wr & h_ctrl & ~pwdata[`PIS_B_GHI] & ~pwdata[`PIS_B_GLO];
  wire [20:0] tbl_addr = 21'(ivt + {17'h0_0000, vec_q, 1'b0});
  wire [20:0] fix_addr = lvl_q ? `PIS_HI_ADDR : `PIS_LO_ADDR;

  // ==========================================================
  // Flags
  for (genvar g = 0; g < NS; g++) begin : g_flag
    if (g == `PIS_SUMMARY_SRC) begin : g_sum
      // summary flag follows its sub-flags, not writable
      assign flag[g] = |sub_flags;
    end else begin : g_bit
      wire clr = (wr & h_flag & pwdata[g]) |
                 (take & (vec_q == 3'(g)) & HW_CLR[g]);
      // event sets; set wins over clear
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          flag[g] <= 1'b0;
        end else begin
          flag[g] <= src_event[g] | (flag[g] & ~clr);
        end
      end
    end
  end

  // ==========================================================
  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `PIS_CTRL_RST;
      enable <= `PIS_ENA_RST;
      prio <= `PIS_PRIO_RST;
      ivt <= `PIS_IVT_RST;
    end else if (wr) begin
      if (h_ctrl) ctrl <= pwdata[4:0];
      if (h_ena) enable <= pwdata[NS-1:0];
      if (h_prio) prio <= pwdata[NS-1:0];
      if (h_ivt) ivt <= pwdata[20:0];
    end
  end

  // ==========================================================
  // Vectoring sequence
  always_comb begin
    next_seq = seq;
    case (seq)
      PIS_IDLE: begin
        if (accept_ok) next_seq = PIS_WAIT;
      end
      PIS_WAIT: begin
        if (!accept_ok) next_seq = PIS_IDLE;
        else if (instr_done) next_seq = PIS_LAT1;
      end
      PIS_LAT1: begin
        // forced no-op when the request vanished
        next_seq = still ? PIS_LAT2 : PIS_IDLE;
      end
      PIS_LAT2: begin
        // vector table adds a third cycle
        next_seq = vten ? PIS_LAT3 : PIS_IDLE;
      end
      default: begin
        next_seq = PIS_IDLE;
      end
    endcase
  end

  always_comb begin
    next_exec = exec;
    if (take) begin
      if (exec == PIS_LOW) next_exec = PIS_HIL;
      else next_exec = lvl_q ? PIS_HIM : PIS_LOW;
    end else if (ret_ok) begin
      // high return resumes the suspended low routine
      next_exec = (exec == PIS_HIL) ? PIS_LOW : PIS_MAIN;
    end else if (force_main) begin
      next_exec = PIS_MAIN;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq <= PIS_IDLE;
      exec <= PIS_MAIN;
      vec_q <= 3'h0;
      lvl_q <= 1'b0;
    end else begin
      seq <= next_seq;
      exec <= next_exec;
      if (seq == PIS_WAIT && next_seq == PIS_LAT1) begin
        vec_q <= sel_vec;
        lvl_q <= sel_lvl;
      end
    end
  end

  // ==========================================================
  // Shadow contexts
  // Hardware save wins over a software write in the same cycle
  wire sw_shd = wr & h_shd;
  // save level follows the state; no nesting without levels
  wire save_main = take & (exec == PIS_MAIN);
  wire save_low = take & (exec == PIS_LOW);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shd_main <= '0;
      shd_low <= '0;
    end else begin
      if (save_main) shd_main <= cpu_ctx;
      // software may rewrite what gets restored
      else if (sw_shd & ~ssel) shd_main <= pis_ctx_wr(shd_main, shd_w, pwdata);
      if (save_low) shd_low <= cpu_ctx;
      else if (sw_shd & ssel) shd_low <= pis_ctx_wr(shd_low, shd_w, pwdata);
    end
  end

  // ==========================================================
  // CPU outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_halt <= 1'b0;
      pc_push <= 1'b0;
      working_register_load <= 1'b0;
      working_register_value <= 8'h00;
    end else begin
      cpu_halt <= (seq == PIS_LAT1) | (seq == PIS_LAT2) | (seq == PIS_LAT3);
      // PC pushed with the context save
      pc_push <= take;
      // vector number after the old value was captured
      working_register_load <= take;
      working_register_value <= take ? {5'h00, vec_q} : working_register_value;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_load <= 1'b0;
      pc_value <= 21'h00_0000;
    end else begin
      pc_load <= (seq == PIS_LAT2) | (seq == PIS_LAT3);
      if (seq == PIS_LAT2) pc_value <= vten ? tbl_addr : fix_addr;
      else if (seq == PIS_LAT3) pc_value <= {fetch_word, 2'b00};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_pop <= 1'b0;
      ctx_restore <= 1'b0;
      ctx_out <= '0;
    end else begin
      // return pops; restore only with operand 1
      pc_pop <= ret_ok;
      ctx_restore <= ret_ok & return_from_interrupt_restore;
      // high exit from low restores low; every other exit restores main
      if (ret_ok & return_from_interrupt_restore) ctx_out <= (exec == PIS_HIL) ? shd_low : shd_main;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence sq_vt_lat;
    seq == PIS_LAT2 ##1 seq == PIS_LAT3 ##1 seq == PIS_IDLE;
  endsequence
  sequence sq_nv_lat;
    seq == PIS_LAT2 ##1 seq == PIS_IDLE;
  endsequence

  a_vt_latency: assert property (take && vten |=> sq_vt_lat ##0 pc_load)
    else $error("vector table latency not three cycles");
  a_nv_latency: assert property (take && !vten |=> sq_nv_lat ##0 pc_load && pc_value == $past(fix_addr))
    else $error("non-vectored latency not two cycles");
  a_abort_nop: assert property (seq == PIS_LAT1 && !still |=> seq == PIS_IDLE && cpu_halt ##1 !cpu_halt)
    else $error("abort did not give one forced no-op");
  a_drop_req: assert property (seq == PIS_WAIT && !accept_ok |=> seq == PIS_IDLE && !cpu_halt)
    else $error("cleared request was not dropped");
  a_working_register_vec: assert property (take |=> working_register_load && working_register_value == {5'h00, $past(vec_q)})
    else $error("vector number not loaded");
  a_low_takes_high: assert property (take && exec == PIS_LOW |-> lvl_q ##1 exec == PIS_HIL)
    else $error("low routine accepted a low request");
  a_high_first: assert property (seq == PIS_WAIT && instr_done && |hi_m |=> lvl_q)
    else $error("low request served before high");
  a_natural_order: assert property (seq == PIS_WAIT && instr_done && hi_m[0] |=> vec_q == 3'h0)
    else $error("lowest vector not chosen");
  a_restore_low: assert property (ret_ok && return_from_interrupt_restore && exec == PIS_HIL
    |=> ctx_restore && ctx_out == $past(shd_low) && exec == PIS_LOW)
    else $error("high exit did not restore low context");
  a_no_restore: assert property (ret_ok && !return_from_interrupt_restore |=> pc_pop && !ctx_restore)
    else $error("return without restore restored context");
  a_save_main: assert property (save_main |=> shd_main == $past(cpu_ctx) && pc_push)
    else $error("main context not saved on entry");

endmodule : pis_core
`default_nettype wire

/* verif/pis_cpu_model.sv */
// CPU core model facing the interrupt sequencer: instruction stream,
// register context, vector table memory and returns on command.
// Assumes the same pclk as the sequencer; the bench orders stalls and returns.
`default_nettype none
module pis_cpu_model
  import pis_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench commands
  input wire logic stall,
  input wire logic do_ret,
  input wire logic ret_rst,
  // Sequencer side
  input wire logic cpu_halt,
  input wire logic [20:0] pc_value,
  output logic instr_done,
  output logic ret_pulse,
  output logic ret_keep,
  output logic [18:0] fetch_word,
  output var pis_ctx_t cpu_ctx
);
  timeunit 1ns;
  timeprecision 100ps;

  // ========================================
  // Vector table memory
  // routine address fetch
  assign fetch_word = pc_value[18:0] ^ 19'h1_2345;

  // ========================================
  // Instruction stream
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_done <= 1'b0;
      ret_pulse <= 1'b0;
      ret_keep <= 1'b0;
      cpu_ctx <= '0;
    end else begin
      instr_done <= !stall && !cpu_halt;
      ret_pulse <= do_ret;
      ret_keep <= ret_rst;
      // Every byte moves so a wrong restore cannot hide
      if (instr_done && !cpu_halt) begin
        cpu_ctx <= pis_ctx_t'(cpu_ctx + {13{8'h1d}});
      end
    end
  end
endmodule : pis_cpu_model
`default_nettype wire

/* verif/priority_interrupt_sequencer_bench.sv */
// Self-checking bench of the interrupt sequencer with a CPU core model.
// Assumes pis_core, pis_cpu_model and pis_cfg.svh on the include path.
`include "pis_cfg.svh"
`default_nettype none
module priority_interrupt_sequencer_bench
  import pis_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ========================================
  // Signals and reference model state
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, stall = 1'b0, do_ret = 1'b0, ret_rst = 1'b0;
  logic [7:0] paddr = '0, src_event = '0, working_register_value;
  logic [31:0] pwdata = '0, prdata, r;
  logic [31:0] seed = 32'hfa40;
  logic [3:0] sub_flags = '0;
  logic pready, pslverr, instr_done, ret_pulse, ret_keep, cpu_halt, pc_push, pc_pop, pc_load;
  logic working_register_load, ctx_restore;
  logic [18:0] fetch_word;
  logic [20:0] pc_value, ivt;
  pis_ctx_t cpu_ctx, ctx_out;
  pis_ctx_t saved[$];
  int errors = 0, n_checks = 0, n_ent = 0, ex = 0, n_halt = 0;
  logic [7:0] rst_a[6] = '{`PIS_A_CTRL, `PIS_A_STAT, `PIS_A_ENA, `PIS_A_PRIO, `PIS_A_IVT, 8'hfc};
  logic [31:0] rst_v[6] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_00ff, 32'h0000_0008, 32'h0000_0000};

  always #2.5 pclk = ~pclk;
  always @(posedge pclk) if (working_register_load === 1'b1) n_ent++;
  always @(posedge pclk) if (cpu_halt === 1'b1) n_halt++;

  pis_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_event(src_event), .sub_flags(sub_flags), .instr_done(instr_done), .return_from_interrupt(ret_pulse),
    .return_from_interrupt_restore(ret_keep), .fetch_word(fetch_word), .cpu_ctx(cpu_ctx), .cpu_halt(cpu_halt),
    .pc_push(pc_push), .pc_pop(pc_pop), .pc_load(pc_load), .pc_value(pc_value), .working_register_load(working_register_load),
    .working_register_value(working_register_value), .ctx_restore(ctx_restore), .ctx_out(ctx_out));

  pis_cpu_model cpu (.pclk(pclk), .presetn(presetn), .stall(stall), .do_ret(do_ret), .ret_rst(ret_rst),
    .cpu_halt(cpu_halt), .pc_value(pc_value), .instr_done(instr_done), .ret_pulse(ret_pulse),
    .ret_keep(ret_keep), .fetch_word(fetch_word), .cpu_ctx(cpu_ctx));

  // ========================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic chk(input string what, input logic [103:0] exp, input logic [103:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic final_report();
    if (errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  // One APB transfer; read data lands in r
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Access phase holds until pready; only the watchdog ends a hang
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    chk("pslverr", a == 8'hfc, pslverr);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic ev(input logic [7:0] m);
    @(posedge pclk);
    src_event <= m;
    @(posedge pclk);
    src_event <= '0;
  endtask : ev

  task automatic clr(input logic [31:0] m);
    apb(1'b1, `PIS_A_FLAG, m);
  endtask : clr

  // Follows one vectoring and checks it against the reference model
  task automatic entry(input int vec, input logic hi, input logic vt);
    pis_ctx_t c1;
    logic [20:0] tbl;
    int k;
    int h;
    tbl = ivt + 21'(2 * vec);
    h = 1;
    for (k = 0; k < 40 && working_register_load !== 1'b1; k++) begin
      c1 = cpu_ctx;
      @(negedge pclk);
    end
    chk("working_register_value", 8'(vec), working_register_value);
    chk("pc_push", 1'b1, pc_push);
    for (k = 0; k < 3; k++) begin
      @(negedge pclk);
      h += int'(cpu_halt);
      if (k == 0) chk("pc_first", {1'b1, vt ? tbl : (hi ? `PIS_HI_ADDR : `PIS_LO_ADDR)}, {pc_load, pc_value});
      if (k == 1 && vt) chk("pc_isr", {1'b1, tbl[18:0] ^ 19'h1_2345, 2'b00}, {pc_load, pc_value});
    end
    chk("halt_cycles", vt ? 3 : 2, h);
    saved.push_back(c1);
    ex = (ex == 1) ? 3 : (hi ? 2 : 1);
    apb(1'b0, `PIS_A_STAT, '0);
    chk("exec", ex[1:0], r[1:0]);
  endtask : entry

  task automatic ret(input logic rst);
    pis_ctx_t e;
    int k;
    e = saved.pop_back();
    @(posedge pclk);
    do_ret <= 1'b1;
    ret_rst <= rst;
    @(posedge pclk);
    do_ret <= 1'b0;
    for (k = 0; k < 20 && pc_pop !== 1'b1; k++) @(negedge pclk);
    chk("pop_restore", {1'b1, rst}, {pc_pop, ctx_restore});
    if (rst) chk("ctx_out", e, ctx_out);
    ex = (ex == 3) ? 1 : 0;
  endtask : ret

  // ========================================
  // Scenarios
  initial begin
    int k;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rst_a[i]) begin
      apb(1'b0, rst_a[i], '0);
      chk("reset_value", rst_v[i], r);
    end
    ivt = 21'(rnd() & 32'h001f_ff00);
    apb(1'b1, `PIS_A_IVT, {11'h000, ivt});
    apb(1'b1, `PIS_A_PRIO, 32'h0000_00e7);
    apb(1'b1, `PIS_A_ENA, 32'h0000_007f);
    apb(1'b1, `PIS_A_CTRL, 32'h0000_000f);
    // Low routine preempted by a high one, then an edited main context
    ev(8'h08);
    entry(3, 1'b0, 1'b1);
    apb(1'b0, `PIS_A_CTRL, '0);
    chk("ctrl_kept", 32'h0000_000f, r);
    clr(32'h0000_0008);
    ev(8'h02);
    entry(1, 1'b1, 1'b1);
    clr(32'h0000_0002);
    ret(1'b1);
    apb(1'b1, `PIS_A_SHD0, rnd());
    saved[0][23:0] = seed[23:0];
    ret(1'b1);
    // Simultaneous events: two high, one low
    ev(8'h34);
    entry(2, 1'b1, 1'b1);
    clr(32'h0000_0004);
    ret(1'b0);
    entry(5, 1'b1, 1'b1);
    clr(32'h0000_0020);
    ret(1'b1);
    entry(4, 1'b0, 1'b1);
    clr(32'h0000_0010);
    ret(1'b1);
    // Hardware-cleared source and the read-only summary
    ev(8'h40);
    entry(6, 1'b1, 1'b1);
    apb(1'b0, `PIS_A_FLAG, '0);
    chk("flag_hw_clear", 32'h0000_0000, r);
    ret(1'b1);
    @(posedge pclk) sub_flags <= 4'h2;
    clr(32'h0000_0080);
    apb(1'b0, `PIS_A_FLAG, '0);
    chk("flag_summary", 32'h0000_0080, r);
    @(posedge pclk) sub_flags <= '0;
    apb(1'b0, `PIS_A_FLAG, '0);
    chk("flag_summary", 32'h0000_0000, r);
    // Request withdrawn while the CPU is still busy
    @(posedge pclk) stall <= 1'b1;
    ev(8'h01);
    k = n_ent;
    clr(32'h0000_0001);
    @(posedge pclk) stall <= 1'b0;
    repeat (20) @(posedge pclk);
    chk("aborted", k, n_ent);
    // Clear lands with the instruction that lets vectoring start
    @(posedge pclk) stall <= 1'b1;
    ev(8'h01);
    k = n_halt;
    fork
      clr(32'h0000_0001);
      begin
        @(posedge pclk);
        stall <= 1'b0;
      end
    join
    repeat (20) @(posedge pclk);
    chk("abort_nop", k + 1, n_halt);
    // Fixed addresses without the vector table, then one level only
    apb(1'b1, `PIS_A_CTRL, 32'h0000_0007);
    ev(8'h01);
    entry(0, 1'b1, 1'b0);
    clr(32'h0000_0001);
    ret(1'b1);
    ev(8'h08);
    entry(3, 1'b0, 1'b0);
    clr(32'h0000_0008);
    ret(1'b1);
    apb(1'b1, `PIS_A_CTRL, 32'h0000_0001);
    ev(8'h08);
    entry(3, 1'b1, 1'b0);
    clr(32'h0000_0008);
    ret(1'b1);
    final_report();
  end

  // Cuts a hang short
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    final_report();
  end
endmodule : priority_interrupt_sequencer_bench
`default_nettype wire
